// >>> src/rxport_params.svh
`ifndef RXPORT_PARAMS_SVH
`define RXPORT_PARAMS_SVH
// register byte offsets
`define RXP_CTRL_OFS 4'h0
`define RXP_STAT_OFS 4'h4
`define RXP_VIOL_OFS 4'h8
// control field positions
`define RXP_CTRL_POL_LSB 0
`define RXP_CTRL_EXT_BIT 2
`define RXP_CTRL_QEN_BIT 3
`define RXP_CTRL_DEC_BIT 4
// control reset value: queue enabled, decoder enabled, utopia timing
`define RXP_CTRL_RST 5'h18
// status field positions
`define RXP_STAT_EMPTY_BIT 9
`define RXP_STAT_HALF_BIT 10
`define RXP_STAT_FULL_BIT 11
`define RXP_STAT_PASS_LSB 16
// timing counts
`define RXP_RST_SAMPLES 4'h8
`define RXP_FULL_ROOM 9'h008
// self-test sequence
`define RXP_SEQ_LEN 9'h1ff
`define RXP_LFSR_SEED 9'h1ff
`define RXP_K285 10'h0bc
`endif

// >>> src/rxport_pkg.sv
package rxport_pkg;
`include "rxport_params.svh"
  typedef struct packed {
    logic dec_en;
    logic queue_en;
    logic ext_sel;
    logic [1:0] discard_policy;
  } ctrl_t;

  typedef struct packed {
    logic [9:0] data;
    logic is_k285;
  } rx_char_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [7:0] wr_ptr;
    logic [7:0] rd_ptr;
    logic [8:0] count;
    logic [3:0] rst_cnt;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [8:0] lfsr;
    logic [8:0] seq_cnt;
    logic [15:0] pass_cnt;
    logic [15:0] viol_cnt;
    logic waitreq;
    logic [31:0] rdata;
    logic [9:0] bus_data;
    logic bus_oe;
    logic flag_oe;
    logic empty_n;
    logic full_n;
    logic half_n;
    logic tx_queue_full_n_n;
    logic tx_queue_empty_n_n;
    logic viol;
    logic reframe;
    logic [9:0] enc_data;
    logic tx_ref_clk;
  } state_t;
endpackage

// >>> src/rx_port_ctrl.sv
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module rx_port_ctrl
  import rxport_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire rx_char_t i_rx_char,
  input wire logic i_rx_char_valid,
  input wire logic [9:0] i_tx_queue_data,
  input wire logic i_tx_full,
  input wire logic i_tx_empty,
  input wire logic i_address_match_n,
  input wire logic i_receive_enable_n,
  input wire logic i_rx_queue_reset_n,
  input wire logic i_reframe_enable,
  input wire logic i_rx_selftest_enable_n,
  input wire logic i_serial_loopthrough_select,
  output logic [9:0] o_receive_data_bus,
  output logic o_receive_data_bus_oe,
  output logic o_rx_queue_empty_n,
  output logic o_rx_queue_full_n,
  output logic o_rx_queue_half_n,
  output logic o_tx_queue_full_n,
  output logic o_tx_queue_empty_n,
  output logic o_queue_flags_oe,
  output logic o_rx_violation_flag,
  output logic o_aligner_reframe,
  output logic [9:0] o_tx_encoder_data,
  output logic o_tx_if_on_reference_clock
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // pointers are 8 bits wide, so the array cannot pass 256 words
  if (DEPTH != 256 && DEPTH != 128 && DEPTH != 64 && DEPTH != 32) begin : g_bad_depth
    $error("rx_port_ctrl: DEPTH must be 32, 64, 128 or 256");
  end

  localparam logic [8:0] DEPTH_C = 9'(DEPTH);
  localparam logic [8:0] HALF_C = 9'(DEPTH / 2);
  localparam logic [7:0] PTR_MASK = 8'(DEPTH - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // drive a flag at the level the timing mode asks for
  function automatic logic flag_level(input logic asserted, input logic ext);
    flag_level = ext ? asserted : ~asserted;
  endfunction

  // fill characters count as rejected unless discard policy is zero; only the bypass empty flag uses this
  function automatic logic fill_rejected(input logic [1:0] policy, input rx_char_t ch);
    fill_rejected = ch.is_k285 && (policy != 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t st_ff;
  state_t nxt_st;
  rx_char_t mem [DEPTH];
  rx_char_t rd_char;

  logic addressed;
  logic rx_en;
  logic reset_req;
  logic selftest;
  logic loop_sel;
  logic do_push;
  logic do_pop;
  logic q_empty;
  logic q_full;
  logic [8:0] room;
  logic expect_mis;
  logic pass_done;
  logic bus_hit;
  logic [31:0] rd_word;

  assign rd_char = mem[st_ff.rd_ptr];

  always_comb begin
    nxt_st = st_ff;
    // enables and resets count only with address match
    // address qualification
    addressed = ~i_address_match_n;
    rx_en = addressed & flag_level(i_receive_enable_n, st_ff.ctrl.ext_sel);
    reset_req = addressed & ~i_rx_queue_reset_n;

    nxt_st.sync1 = {i_serial_loopthrough_select, ~i_rx_selftest_enable_n,
                    i_reframe_enable};
    nxt_st.sync2 = st_ff.sync1;
    selftest = st_ff.sync2[1];
    loop_sel = st_ff.sync2[2];

    q_empty = (st_ff.count == 9'h000);
    q_full = (st_ff.count == DEPTH_C);
    room = DEPTH_C - st_ff.count;

    // characters arriving at a full queue are lost
    do_push = st_ff.ctrl.queue_en & i_rx_char_valid & ~q_full & ~selftest;
    do_pop = st_ff.ctrl.queue_en & rx_en & ~q_empty;

    if (do_push) begin
      nxt_st.wr_ptr = (st_ff.wr_ptr + 8'h01) & PTR_MASK;
    end
    if (do_pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr + 8'h01) & PTR_MASK;
    end
    nxt_st.count = st_ff.count + {8'h00, do_push} - {8'h00, do_pop};

    if (st_ff.ctrl.queue_en && reset_req) begin
      if (st_ff.rst_cnt != `RXP_RST_SAMPLES) begin
        nxt_st.rst_cnt = st_ff.rst_cnt + 4'h1;
      end
    end else begin
      nxt_st.rst_cnt = 4'h0;
    end
    // the reset fires on every cycle the held count sits at eight; holding longer keeps it empty
    if (st_ff.rst_cnt == `RXP_RST_SAMPLES) begin
      nxt_st.wr_ptr = 8'h00;
      nxt_st.rd_ptr = 8'h00;
      nxt_st.count = 9'h000;
    end

    // ---- receive data bus ----
    nxt_st.bus_oe = rx_en;
    if (st_ff.ctrl.queue_en) begin
      if (do_pop) begin
        nxt_st.bus_data = rd_char.data;
      end
    end else if (rx_en && i_rx_char_valid) begin
      nxt_st.bus_data = i_rx_char.data;
    end

    // ---- empty flag ----
    if (st_ff.ctrl.queue_en) begin
      nxt_st.empty_n = flag_level(nxt_st.count == 9'h000, st_ff.ctrl.ext_sel);
    end else if (!st_ff.ctrl.dec_en) begin
      nxt_st.empty_n = flag_level(1'b0, st_ff.ctrl.ext_sel);
    end else if (i_rx_char_valid) begin
      nxt_st.empty_n = flag_level(fill_rejected(st_ff.ctrl.discard_policy, i_rx_char),
                                  st_ff.ctrl.ext_sel);
    end
    if (st_ff.ctrl.ext_sel != nxt_st.ctrl.ext_sel) begin
      nxt_st.empty_n = ~nxt_st.empty_n;
    end

    // ---- self-test ----
    expect_mis = 1'b0;
    pass_done = 1'b0;
    nxt_st.viol = 1'b0;
    if (!selftest) begin
      nxt_st.lfsr = `RXP_LFSR_SEED;
      nxt_st.seq_cnt = 9'h000;
    end else if (i_rx_char_valid) begin
      expect_mis = i_rx_char.data != {1'b0, st_ff.lfsr};
      nxt_st.viol = expect_mis;
      if (expect_mis) begin
        nxt_st.viol_cnt = st_ff.viol_cnt + 16'h0001;
      end
      nxt_st.lfsr = {st_ff.lfsr[7:0], st_ff.lfsr[8] ^ st_ff.lfsr[4]};
      pass_done = (st_ff.seq_cnt == `RXP_SEQ_LEN - 9'h001);
      nxt_st.seq_cnt = pass_done ? 9'h000 : st_ff.seq_cnt + 9'h001;
      if (pass_done) begin
        nxt_st.pass_cnt = st_ff.pass_cnt + 16'h0001;
      end
    end

    // ---- full and half flags ----
    if (pass_done) begin
      nxt_st.full_n = flag_level(1'b1, st_ff.ctrl.ext_sel);
    end else begin
      nxt_st.full_n = flag_level(st_ff.ctrl.queue_en & rx_en & (room <= `RXP_FULL_ROOM),
                                 st_ff.ctrl.ext_sel);
    end
    nxt_st.half_n = ~(st_ff.ctrl.queue_en & (st_ff.count >= HALF_C));
    nxt_st.tx_queue_full_n_n = flag_level(i_tx_full, st_ff.ctrl.ext_sel);
    nxt_st.tx_queue_empty_n_n = flag_level(i_tx_empty, st_ff.ctrl.ext_sel);
    nxt_st.flag_oe = addressed;

    nxt_st.reframe = st_ff.sync2[0];
    nxt_st.enc_data = (loop_sel && st_ff.ctrl.queue_en) ? i_rx_char.data : i_tx_queue_data;
    nxt_st.tx_ref_clk = ~st_ff.ctrl.queue_en;

    // ---- register bus ----
    bus_hit = (i_avs_read | i_avs_write) & st_ff.waitreq;
    unique case (i_avs_address)
      `RXP_CTRL_OFS: rd_word = {27'h000_0000, st_ff.ctrl};
      `RXP_STAT_OFS: rd_word = {st_ff.pass_cnt, 4'h0, ~st_ff.full_n ^ st_ff.ctrl.ext_sel,
                                ~st_ff.half_n, q_empty, st_ff.count};
      `RXP_VIOL_OFS: rd_word = {16'h0000, st_ff.viol_cnt};
      default: rd_word = 32'h0000_0000;
    endcase
    nxt_st.waitreq = ~bus_hit;
    if (bus_hit && i_avs_read) begin
      nxt_st.rdata = rd_word;
    end
    if (!st_ff.waitreq && i_avs_write) begin
      case (i_avs_address)
        `RXP_CTRL_OFS: begin
          nxt_st.ctrl = ctrl_t'(i_avs_writedata[4:0]);
        end
        `RXP_VIOL_OFS: begin
          // a mismatch in the clearing cycle still counts
          nxt_st.viol_cnt = {15'h0000, nxt_st.viol};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_ff <= '0;
      st_ff.ctrl <= ctrl_t'(`RXP_CTRL_RST);
      st_ff.lfsr <= `RXP_LFSR_SEED;
      st_ff.waitreq <= 1'b1;
      st_ff.empty_n <= 1'b0;
      st_ff.full_n <= 1'b1;
      st_ff.half_n <= 1'b1;
      st_ff.tx_queue_full_n_n <= 1'b1;
      st_ff.tx_queue_empty_n_n <= 1'b1;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  // storage has no reset; pointers define what is valid
  always_ff @(posedge i_clk) begin
    if (i_ce && do_push) begin
      mem[st_ff.wr_ptr] <= i_rx_char;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_avs_readdata = st_ff.rdata;
  assign o_avs_waitrequest = st_ff.waitreq;
  assign o_receive_data_bus = st_ff.bus_data;
  assign o_receive_data_bus_oe = st_ff.bus_oe;
  assign o_rx_queue_empty_n = st_ff.empty_n;
  assign o_rx_queue_full_n = st_ff.full_n;
  assign o_rx_queue_half_n = st_ff.half_n;
  assign o_tx_queue_full_n = st_ff.tx_queue_full_n_n;
  assign o_tx_queue_empty_n = st_ff.tx_queue_empty_n_n;
  assign o_queue_flags_oe = st_ff.flag_oe;
  assign o_rx_violation_flag = st_ff.viol;
  assign o_aligner_reframe = st_ff.reframe;
  assign o_tx_encoder_data = st_ff.enc_data;
  assign o_tx_if_on_reference_clock = st_ff.tx_ref_clk;

endmodule // rx_port_ctrl

// >>> dv/rx_port_ctrl_properties.sv
`timescale 1ns/100ps
module rx_port_ctrl_properties (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_rx_char_valid,
  input wire logic [9:0] i_tx_queue_data,
  input wire logic i_address_match_n,
  input wire logic i_reframe_enable,
  input wire logic i_rx_selftest_enable_n,
  input wire logic i_serial_loopthrough_select,
  input wire logic o_receive_data_bus_oe,
  input wire logic o_rx_queue_half_n,
  input wire logic o_queue_flags_oe,
  input wire logic o_rx_violation_flag,
  input wire logic o_aligner_reframe,
  input wire logic [9:0] o_tx_encoder_data,
  input wire logic o_tx_if_on_reference_clock
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ---------------------------------
  // five-sample windows cover the synchronizer plus output register
  // ---------------------------------
  a_bus_answer: assert property ( // avalon
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
  a_flags_oe_follow: assert property (
    $past(i_nrst) |-> o_queue_flags_oe == !$past(i_address_match_n)) else $error("flag enable");
  a_bus_oe_cause: assert property (
    o_receive_data_bus_oe |-> !$past(i_address_match_n)) else $error("bus enable");
  a_half_bypass: assert property (
    o_tx_if_on_reference_clock && $past(o_tx_if_on_reference_clock) |-> o_rx_queue_half_n)
    else $error("half flag");
  a_viol_cause: assert property (
    o_rx_violation_flag |-> $past(i_rx_char_valid)) else $error("violation cause");
  a_viol_quiet: assert property (
    i_rx_selftest_enable_n [*5] |-> !o_rx_violation_flag) else $error("violation off");
  a_loop_source: assert property (
    !i_serial_loopthrough_select [*5] |-> o_tx_encoder_data == $past(i_tx_queue_data))
    else $error("encoder source");
  a_reframe_follow: assert property (
    $stable(i_reframe_enable) [*5] |-> o_aligner_reframe == i_reframe_enable) else $error("reframe");
endmodule // rx_port_ctrl_properties

bind rx_port_ctrl rx_port_ctrl_properties u_rx_port_ctrl_properties (.*);

// >>> dv/rx_host_model.sv
`timescale 1ns/100ps
module rx_host_model (
  input wire logic i_clk,
  input wire logic i_en_level,
  input wire logic [9:0] i_receive_data_bus,
  input wire logic i_receive_data_bus_oe,
  output logic o_address_match_n,
  output logic o_receive_enable_n,
  output logic o_rx_queue_reset_n
);
  logic [9:0] got_q[$];
  initial begin
    o_address_match_n = 1'b1;
    o_receive_enable_n = 1'b1;
    o_rx_queue_reset_n = 1'b1;
  end
  always @(posedge i_clk) begin
    if (i_receive_data_bus_oe) begin
      got_q.push_back(i_receive_data_bus);
    end
  end
  task drive(input logic am, input logic en, input logic rst, input int n);
    o_address_match_n <= !am;
    o_receive_enable_n <= en ? i_en_level : !i_en_level;
    o_rx_queue_reset_n <= !rst;
    repeat (n) @(posedge i_clk);
    o_address_match_n <= 1'b1;
    o_receive_enable_n <= !i_en_level;
    o_rx_queue_reset_n <= 1'b1;
    @(posedge i_clk);
  endtask
endmodule // rx_host_model

// >>> dv/rx_port_ctrl_tb.sv
`timescale 1ns/100ps
module rx_port_ctrl_tb;
  import rxport_pkg::*;
  logic i_clk, i_nrst, i_ce, i_avs_read, i_avs_write, i_rx_char_valid, i_tx_full, i_tx_empty;
  logic i_address_match_n, i_receive_enable_n, i_rx_queue_reset_n, i_reframe_enable, en_lvl;
  logic i_rx_selftest_enable_n, i_serial_loopthrough_select, o_avs_waitrequest;
  logic o_receive_data_bus_oe, o_rx_queue_empty_n, o_rx_queue_full_n, o_rx_queue_half_n;
  logic o_tx_queue_full_n, o_tx_queue_empty_n, o_queue_flags_oe, o_rx_violation_flag;
  logic o_aligner_reframe, o_tx_if_on_reference_clock;
  logic [3:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, word;
  logic [9:0] i_tx_queue_data, o_receive_data_bus, o_tx_encoder_data;
  rx_char_t i_rx_char;
  int miscompares, cmp_count, cyc, pulses;

  rx_port_ctrl u_rx_port_ctrl (.*);
  rx_host_model u_rx_host_model (
    .i_clk(i_clk),
    .i_en_level(en_lvl),
    .i_receive_data_bus(o_receive_data_bus),
    .i_receive_data_bus_oe(o_receive_data_bus_oe),
    .o_address_match_n(i_address_match_n),
    .o_receive_enable_n(i_receive_enable_n),
    .o_rx_queue_reset_n(i_rx_queue_reset_n)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // hang guard; self-test needs about 600 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (!i_rx_selftest_enable_n && !o_rx_queue_full_n) pulses <= pulses + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // ---------------------------------
  // tasks
  // ---------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task avs(input logic w, input logic [3:0] a, input logic [31:0] d);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_clk);
    word = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_clk);
  endtask
  task push(input logic [9:0] d, input logic k, input logic [9:0] step, input int n);
    for (int j = 0; j < n; j++) begin
      i_rx_char <= '{d + step * j[9:0], k};
      i_rx_char_valid <= 1'b1;
      @(posedge i_clk);
    end
    i_rx_char_valid <= 1'b0;
    @(posedge i_clk);
  endtask
  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ---------------------------------
  // tests
  // ---------------------------------
  initial begin
    {i_avs_read, i_avs_write, i_rx_char_valid, i_tx_full, i_tx_empty, en_lvl} = '0;
    {i_reframe_enable, i_serial_loopthrough_select, i_avs_address, i_avs_writedata} = '0;
    i_rx_char = '0;
    i_nrst = 1'b0;
    i_ce = 1'b1;
    i_rx_selftest_enable_n = 1'b1;
    i_tx_queue_data = 10'h2a5;
    tick(6);
    i_nrst <= 1'b1;
    tick(1);
    avs(1'b0, 4'h0, '0);
    chk("ctrl", 32'h0000_0018, word);
    avs(1'b0, 4'h4, '0);
    chk("status", 32'h0000_0200, word);
    avs(1'b0, 4'hc, '0);
    chk("unmapped", 32'h0000_0000, word);
    u_rx_host_model.drive(1'b1, 1'b0, 1'b0, 2);
    chk("empty low", 32'h0000_0000, o_rx_queue_empty_n);
    chk("flag oe", 32'h0000_0001, o_queue_flags_oe);
    tick(1);
    chk("flag hiz", 32'h0000_0000, o_queue_flags_oe);
    $display("test reset done");
    push(10'h101, 1'b0, 10'h001, 3);
    tick(2);
    avs(1'b0, 4'h4, '0);
    chk("count", 32'h0000_0003, word);
    u_rx_host_model.drive(1'b0, 1'b1, 1'b0, 3);
    chk("no pop", 32'h0000_0000, u_rx_host_model.got_q.size());
    u_rx_host_model.drive(1'b1, 1'b1, 1'b0, 5);
    tick(1);
    chk("pops", 32'h0000_0005, u_rx_host_model.got_q.size());
    foreach (u_rx_host_model.got_q[i]) begin
      chk("pop data", 32'h0000_0101 + (i < 2 ? i : 2), u_rx_host_model.got_q[i]);
    end
    avs(1'b0, 4'h4, '0);
    chk("drained", 32'h0000_0200, word);
    push(10'h0aa, 1'b0, 10'h000, 2);
    u_rx_host_model.drive(1'b0, 1'b0, 1'b1, 8);
    avs(1'b0, 4'h4, '0);
    chk("rst no am", 32'h0000_0002, word[8:0]);
    u_rx_host_model.drive(1'b1, 1'b0, 1'b1, 7);
    avs(1'b0, 4'h4, '0);
    chk("rst 7", 32'h0000_0002, word[8:0]);
    u_rx_host_model.drive(1'b1, 1'b0, 1'b1, 8);
    avs(1'b0, 4'h4, '0);
    chk("rst 8", 32'h0000_0200, word);
    avs(1'b1, 4'h0, 32'h0000_001c);
    en_lvl <= 1'b1;
    u_rx_host_model.drive(1'b1, 1'b0, 1'b0, 2);
    chk("empty high", 32'h0000_0001, o_rx_queue_empty_n);
    i_tx_full <= 1'b1;
    tick(2);
    chk("tx full high", 32'h0000_0001, o_tx_queue_full_n);
    chk("tx empty low", 32'h0000_0000, o_tx_queue_empty_n);
    $display("test queue done");
    for (int p = 0; p < 4; p++) begin
      avs(1'b1, 4'h0, 32'h0000_0010 | p);
      push(10'h0bc, 1'b1, 10'h000, 1);
      tick(2);
      chk("fill flag", {31'h0000_0000, p == 0}, o_rx_queue_empty_n);
    end
    chk("half", 32'h0000_0001, o_rx_queue_half_n);
    chk("tx full low", 32'h0000_0000, o_tx_queue_full_n);
    i_tx_full <= 1'b0;
    chk("reference_clock", 32'h0000_0001, o_tx_if_on_reference_clock);
    avs(1'b1, 4'h0, 32'h0000_0000);
    push(10'h0bc, 1'b1, 10'h000, 1);
    tick(2);
    chk("raw flag", 32'h0000_0001, o_rx_queue_empty_n);
    $display("test bypass done");
    avs(1'b1, 4'h0, 32'h0000_0018);
    en_lvl <= 1'b0;
    push(10'h000, 1'b0, 10'h001, 248);
    chk("half low", 32'h0000_0000, o_rx_queue_half_n);
    u_rx_host_model.drive(1'b1, 1'b1, 1'b0, 1);
    chk("full", 32'h0000_0000, o_rx_queue_full_n);
    u_rx_host_model.drive(1'b1, 1'b0, 1'b1, 8);
    for (int v = 1; v >= 0; v--) begin
      i_serial_loopthrough_select <= v[0];
      i_reframe_enable <= v[0];
      tick(5);
      push(10'h0aa, 1'b0, 10'h000, 1);
      tick(2);
      chk("encoder", v ? 32'h0000_00aa : 32'h0000_02a5, o_tx_encoder_data);
      chk("reframe", v, o_aligner_reframe);
    end
    $display("test loop done");
    i_rx_selftest_enable_n <= 1'b0;
    tick(5);
    push(10'h000, 1'b0, 10'h000, 511);
    tick(3);
    avs(1'b0, 4'h8, '0);
    chk("mismatches", 32'h0000_01ff, word);
    avs(1'b0, 4'h4, '0);
    chk("passes", 32'h0000_0001, word[31:16]);
    chk("full pulses", 32'h0000_0001, pulses);
    avs(1'b1, 4'h8, '0);
    avs(1'b0, 4'h8, '0);
    chk("viol clear", 32'h0000_0000, word);
    i_rx_selftest_enable_n <= 1'b1;
    $display("test selftest done");
    close_out();
  end
endmodule // rx_port_ctrl_tb
